/* ptc_capture.sv */
module ptc_capture
	import ptc_pkg::*;
(
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [AXI_AW-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic      [1:0]        s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [AXI_AW-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic      [31:0]       s_axi_rdata,
	output logic      [1:0]        s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire logic              ts_valid,
	input  wire logic              ts_sop,
	input  wire logic [7:0]        ts_data,
	output logic                   mem_wvalid,
	output logic      [31:0]       mem_waddr,
	output logic      [7:0]        mem_wdata,
	output logic                   irq
);

	ptc_state_s s_reg;
	ptc_state_s s_next;

	logic [IDX_W-1:0] cur_idx;
	logic             in_pkt;
	logic             pkt_pusi;
	logic [PID_W-1:0] pkt_pid;
	logic [4:0]       pid_hi;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [31:0] merge(
		input logic [31:0] old_v,
		input logic [31:0] new_v,
		input logic [3:0]  strb
	);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++)
		begin
			if (strb[i])
				r[i*8 +: 8] = new_v[i*8 +: 8];
		end
		return r;
	endfunction

	function automatic logic [31:0] sense_word(
		input logic             en,
		input logic [PID_W-1:0] id
	);
		logic [31:0] r;
		r = '0;
		r[SENSE_EN_BIT] = en;
		r[PID_W-1:0] = id;
		return r;
	endfunction

	function automatic logic [7:0] word_ofs(input logic [AXI_AW-1:0] a);
		return {a[AXI_AW-1:2], 2'b00};
	endfunction

	function automatic logic ofs_mapped(input logic [7:0] o);
		return o == OFS_ASSOC_BASE || o == OFS_MAP_CFG || o == OFS_MAP_BASE
			|| o == OFS_BND_ID || o == OFS_CONTROL_WORD_ZERO || o == OFS_INT_STAT
			|| o == OFS_INT_CLR || o == OFS_INT_EN || o == OFS_ASSOC_CFG;
	endfunction

	// ----------------------------------------
	// packet header tracking
	// ----------------------------------------
	ptc_hdr_parse i_ptc_hdr_parse (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.ts_valid (ts_valid),
		.ts_sop   (ts_sop),
		.ts_data  (ts_data),
		.cur_idx  (cur_idx),
		.in_pkt   (in_pkt),
		.pusi     (pkt_pusi),
		.pid      (pkt_pid),
		.pid_hi   (pid_hi)
	);

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb
	begin
		logic [INT_W-1:0] int_set;
		logic [INT_W-1:0] int_clr;
		logic [1:0]       hit;
		logic [1:0]       newv;
		logic             t;
		logic             tag;
		logic [7:0]       wo;
		logic [7:0]       ro;
		logic [31:0]      rd;
		logic [31:0]      wv;
		int_set = '0;
		int_clr = '0;
		hit     = '0;
		newv    = '0;
		t       = 1'b0;
		tag     = 1'b0;
		wo      = word_ofs(s_reg.aw_addr);
		ro      = word_ofs(s_axi_araddr);
		rd      = '0;
		wv      = '0;
		s_next  = s_reg;
		s_next.mem_wvalid = 1'b0;

		// table selection by packet identifier
		hit[TBL_ASSOC] = pkt_pid == ASSOC_PID;
		hit[TBL_MAP]   = s_reg.map_en && pkt_pid == s_reg.map_pid;
		t = hit[TBL_MAP];

		if (ts_valid && in_pkt)
		begin
			// boundary marker seen as soon as the identifier is complete
			if (cur_idx == IDX_HDR2 && s_reg.bnd_en && {pid_hi, ts_data} == s_reg.bnd_id)
				int_set[INT_BND_BIT] = 1'b1;

			// version decision on the section header of a start packet
			if (cur_idx == IDX_VER && pkt_pusi && (hit != 2'b00))
			begin
				newv[t] = ts_data[CN_BIT] && (!s_reg.seen[t]
					|| ts_data[VER_LSB +: VER_W] != s_reg.ver[t]);
				s_next.active[t] = newv[t];
				if (newv[t])
				begin
					s_next.seen[t] = 1'b1;
					s_next.ver[t]  = ts_data[VER_LSB +: VER_W];
					s_next.ptr[t]  = t ? s_reg.map_base : s_reg.assoc_base;
				end
			end
			if (newv[TBL_ASSOC] && s_reg.assoc_en)
				int_set[INT_ASSOC_BIT] = 1'b1;
			if (newv[TBL_MAP])
				int_set[INT_MAP_BIT] = 1'b1;

			// five-byte delay lets the header bytes wait for the decision
			tag = (hit != 2'b00) && cur_idx >= (pkt_pusi ? IDX_SEC : IDX_PAY);
			if (s_reg.d_tag[DLY-1] && s_next.active[s_reg.d_tbl[DLY-1]])
			begin
				s_next.mem_wvalid = 1'b1;
				s_next.mem_wdata  = s_reg.d_data[DLY-1];
				s_next.mem_waddr  = s_next.ptr[s_reg.d_tbl[DLY-1]];
				s_next.ptr[s_reg.d_tbl[DLY-1]] = s_next.ptr[s_reg.d_tbl[DLY-1]]
					+ 32'h0000_0001;
			end
			s_next.d_data = {s_reg.d_data[DLY-2:0], ts_data};
			s_next.d_tag  = {s_reg.d_tag[DLY-2:0], tag};
			s_next.d_tbl  = {s_reg.d_tbl[DLY-2:0], t};
		end

		// ----------------------------------------
		// bus slave: write channel
		// ----------------------------------------
		if (s_axi_awvalid && s_axi_awready)
		begin
			s_next.aw_full = 1'b1;
			s_next.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			s_next.w_full = 1'b1;
			s_next.w_data = s_axi_wdata;
			s_next.w_strb = s_axi_wstrb;
		end
		if (s_reg.aw_full && s_reg.w_full && !s_reg.bvalid)
		begin
			s_next.aw_full = 1'b0;
			s_next.w_full  = 1'b0;
			s_next.bvalid  = 1'b1;
			s_next.bresp   = ofs_mapped(wo) ? RESP_OKAY : RESP_SLVERR;
			case (wo)
				OFS_ASSOC_BASE: s_next.assoc_base = merge(s_reg.assoc_base, s_reg.w_data,
					s_reg.w_strb);
				OFS_MAP_BASE:   s_next.map_base = merge(s_reg.map_base, s_reg.w_data,
					s_reg.w_strb);
				OFS_MAP_CFG:
				begin
					wv = merge(sense_word(s_reg.map_en, s_reg.map_pid), s_reg.w_data,
						s_reg.w_strb);
					s_next.map_en  = wv[SENSE_EN_BIT];
					s_next.map_pid = wv[PID_W-1:0];
				end
				OFS_ASSOC_CFG:
				begin
					wv = merge(sense_word(s_reg.assoc_en, '0), s_reg.w_data, s_reg.w_strb);
					s_next.assoc_en = wv[SENSE_EN_BIT];
				end
				OFS_BND_ID:
				begin
					wv = merge({19'h0_0000, s_reg.bnd_id}, s_reg.w_data, s_reg.w_strb);
					s_next.bnd_id = wv[PID_W-1:0];
				end
				OFS_CONTROL_WORD_ZERO:
				begin
					wv = merge(32'h0000_0000, s_reg.w_data, s_reg.w_strb);
					if (s_reg.w_strb[0])
						s_next.bnd_en = wv[CONTROL_WORD_ZERO_BND_EN_BIT];
				end
				OFS_INT_EN:
				begin
					if (s_reg.w_strb[0])
						s_next.int_en = s_reg.w_data[INT_W-1:0];
				end
				OFS_INT_CLR:
				begin
					if (s_reg.w_strb[0])
						int_clr = s_reg.w_data[INT_W-1:0];
				end
				default:
				begin
				end
			endcase
		end
		if (s_reg.bvalid && s_axi_bready)
			s_next.bvalid = 1'b0;

		// a new event in the clearing cycle survives the clear
		s_next.int_stat = (s_reg.int_stat & ~int_clr) | int_set;

		// ----------------------------------------
		// bus slave: read channel
		// ----------------------------------------
		case (ro)
			OFS_ASSOC_BASE: rd = s_reg.assoc_base;
			OFS_MAP_CFG:    rd = sense_word(s_reg.map_en, s_reg.map_pid);
			OFS_MAP_BASE:   rd = s_reg.map_base;
			OFS_BND_ID:     rd = {19'h0_0000, s_reg.bnd_id};
			OFS_CONTROL_WORD_ZERO:
			begin
				rd[CONTROL_WORD_ZERO_BND_EN_BIT] = s_reg.bnd_en;
				rd[CONTROL_WORD_ZERO_BND_ST_BIT] = s_reg.int_stat[INT_BND_BIT];
			end
			OFS_INT_STAT:   rd[INT_W-1:0] = s_reg.int_stat;
			OFS_INT_EN:     rd[INT_W-1:0] = s_reg.int_en;
			OFS_ASSOC_CFG:  rd = sense_word(s_reg.assoc_en, '0);
			default:        rd = '0;
		endcase
		if (s_axi_arvalid && s_axi_arready)
		begin
			s_next.rvalid = 1'b1;
			s_next.rdata  = rd;
			s_next.rresp  = ofs_mapped(ro) ? RESP_OKAY : RESP_SLVERR;
		end
		else if (s_reg.rvalid && s_axi_rready)
			s_next.rvalid = 1'b0;
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_reg        <= '0;
			s_reg.bnd_id <= BND_ID_RST;
		end
		else
			s_reg <= s_next;
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	// one write and one read in flight; a held response blocks the next
	assign s_axi_awready = !s_reg.aw_full && !s_reg.bvalid;
	assign s_axi_wready  = !s_reg.w_full && !s_reg.bvalid;
	assign s_axi_bvalid  = s_reg.bvalid;
	assign s_axi_bresp   = s_reg.bresp;
	assign s_axi_arready = !s_reg.rvalid;
	assign s_axi_rvalid  = s_reg.rvalid;
	assign s_axi_rdata   = s_reg.rdata;
	assign s_axi_rresp   = s_reg.rresp;
	assign mem_wvalid    = s_reg.mem_wvalid;
	assign mem_waddr     = s_reg.mem_waddr;
	assign mem_wdata     = s_reg.mem_wdata;
	assign irq           = |(s_reg.int_stat & s_reg.int_en);

endmodule

/* ptc_capture_props.sv */
module ptc_capture_props
	import ptc_pkg::*;
(
	input wire logic              aclk,
	input wire logic              aresetn,
	input wire logic              s_axi_awvalid,
	input wire logic              s_axi_awready,
	input wire logic              s_axi_wvalid,
	input wire logic              s_axi_wready,
	input wire logic              s_axi_bvalid,
	input wire logic [AXI_AW-1:0] s_axi_araddr,
	input wire logic              s_axi_arvalid,
	input wire logic              s_axi_arready,
	input wire logic [31:0]       s_axi_rdata,
	input wire logic [1:0]        s_axi_rresp,
	input wire logic              s_axi_rvalid,
	input wire logic              ts_valid,
	input wire logic              mem_wvalid,
	input wire logic [31:0]       mem_waddr,
	input wire logic              irq
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	a_w_refuse:
		assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write channels open while response pending");
	a_r_refuse:
		assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address open while data pending");
	a_w_answer:
		assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
			|-> ##2 s_axi_bvalid ##1 !s_axi_bvalid)
		else $error("write response late or stuck");
	a_r_answer:
		assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid ##1 !s_axi_rvalid)
		else $error("read data late or stuck");
	a_rd_unmapped:
		assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h23
			|=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
		else $error("unmapped read not refused");
	a_rd_mapped:
		assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr <= 8'h23
			|=> s_axi_rresp == RESP_OKAY)
		else $error("mapped read refused");
	a_mem_idle:
		assert property (!ts_valid |=> !mem_wvalid)
		else $error("memory write without stream byte");
	a_addr_step:
		assert property (mem_wvalid && $past(mem_wvalid) |-> mem_waddr == $past(mem_waddr) + 32'h0000_0001)
		else $error("store address did not advance by one");

	cover property (mem_wvalid && $past(mem_wvalid));
	cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
	cover property ($rose(irq));
endmodule

/* ptc_hdr_parse.sv */
module ptc_hdr_parse
	import ptc_pkg::*;
(
	input  wire logic             aclk,
	input  wire logic             aresetn,
	input  wire logic             ts_valid,
	input  wire logic             ts_sop,
	input  wire logic [7:0]       ts_data,
	output logic      [IDX_W-1:0] cur_idx,
	output logic                  in_pkt,
	output logic                  pusi,
	output logic      [PID_W-1:0] pid,
	output logic      [4:0]       pid_hi
);

	ptc_parse_s p_reg;
	ptc_parse_s p_next;

	// ----------------------------------------
	// byte position and header fields
	// ----------------------------------------
	always_comb
	begin
		p_next = p_reg;
		cur_idx = ts_sop ? '0 : p_reg.idx;
		if (ts_valid && cur_idx < PKT_LEN)
		begin
			p_next.idx = cur_idx + IDX_W'(1);
			if (cur_idx == IDX_HDR1)
			begin
				p_next.pusi = ts_data[PUSI_BIT];
				p_next.pid  = {ts_data[4:0], 8'h00};
			end
			if (cur_idx == IDX_HDR2)
				p_next.pid = {p_reg.pid[PID_W-1:8], ts_data};
		end
	end

	// stray bytes after a full packet are ignored until the next start
	assign in_pkt = cur_idx < PKT_LEN;
	assign pusi   = p_reg.pusi;
	assign pid    = p_reg.pid;
	assign pid_hi = p_reg.pid[PID_W-1:8];

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			p_reg     <= '0;
			p_reg.idx <= PKT_LEN;
		end
		else
			p_reg <= p_next;
	end

endmodule

/* ptc_pkg.sv */
package ptc_pkg;

	// ----------------------------------------
	// register map (byte addresses)
	// ----------------------------------------
	localparam int          AXI_AW            = 8;
	localparam logic [7:0]  OFS_ASSOC_BASE    = 8'h00;
	localparam logic [7:0]  OFS_MAP_CFG       = 8'h04;
	localparam logic [7:0]  OFS_MAP_BASE      = 8'h08;
	localparam logic [7:0]  OFS_BND_ID        = 8'h0c;
	localparam logic [7:0]  OFS_CONTROL_WORD_ZERO         = 8'h10;
	localparam logic [7:0]  OFS_INT_STAT      = 8'h14;
	localparam logic [7:0]  OFS_INT_CLR       = 8'h18;
	localparam logic [7:0]  OFS_INT_EN        = 8'h1c;
	localparam logic [7:0]  OFS_ASSOC_CFG     = 8'h20;

	// ----------------------------------------
	// field layout
	// ----------------------------------------
	localparam int          PID_W             = 13;
	localparam int          SENSE_EN_BIT      = 16;
	localparam int          CONTROL_WORD_ZERO_BND_EN_BIT  = 0;
	localparam int          CONTROL_WORD_ZERO_BND_ST_BIT  = 8;
	localparam int          INT_W             = 4;
	localparam int          INT_BND_BIT       = 0;
	localparam int          INT_ASSOC_BIT     = 2;
	localparam int          INT_MAP_BIT       = 3;
	localparam logic [12:0] BND_ID_RST        = 13'h1fff;
	localparam logic [12:0] ASSOC_PID         = 13'h0000;

	// ----------------------------------------
	// transport packet layout (byte index)
	// ----------------------------------------
	localparam int          IDX_W             = 8;
	localparam logic [7:0]  PKT_LEN           = 8'hbc;
	localparam logic [7:0]  IDX_HDR1          = 8'h01;
	localparam logic [7:0]  IDX_HDR2          = 8'h02;
	localparam logic [7:0]  IDX_PAY           = 8'h04;
	localparam logic [7:0]  IDX_SEC           = 8'h05;
	localparam logic [7:0]  IDX_VER           = 8'h0a;
	localparam int          PUSI_BIT          = 6;
	localparam int          VER_LSB           = 1;
	localparam int          VER_W             = 5;
	localparam int          CN_BIT            = 0;
	localparam int          DLY               = 5;
	localparam int          TBL_ASSOC         = 0;
	localparam int          TBL_MAP           = 1;

	localparam logic [1:0]  RESP_OKAY         = 2'h0;
	localparam logic [1:0]  RESP_SLVERR       = 2'h2;

	typedef struct packed {
		logic [31:0]               assoc_base;
		logic [31:0]               map_base;
		logic                      map_en;
		logic [PID_W-1:0]          map_pid;
		logic [PID_W-1:0]          bnd_id;
		logic                      bnd_en;
		logic                      assoc_en;
		logic [INT_W-1:0]          int_stat;
		logic [INT_W-1:0]          int_en;
		logic [1:0]                seen;
		logic [1:0][VER_W-1:0]     ver;
		logic [1:0]                active;
		logic [1:0][31:0]          ptr;
		logic [DLY-1:0][7:0]       d_data;
		logic [DLY-1:0]            d_tag;
		logic [DLY-1:0]            d_tbl;
		logic                      mem_wvalid;
		logic [31:0]               mem_waddr;
		logic [7:0]                mem_wdata;
		logic                      aw_full;
		logic [AXI_AW-1:0]         aw_addr;
		logic                      w_full;
		logic [31:0]               w_data;
		logic [3:0]                w_strb;
		logic                      bvalid;
		logic [1:0]                bresp;
		logic                      rvalid;
		logic [31:0]               rdata;
		logic [1:0]                rresp;
	} ptc_state_s;

	typedef struct packed {
		logic [IDX_W-1:0]          idx;
		logic                      pusi;
		logic [PID_W-1:0]          pid;
	} ptc_parse_s;

endpackage

/* ptc_ts_source.sv */
module ptc_ts_source (
	input  wire logic       aclk,
	output logic            ts_valid,
	output logic            ts_sop,
	output logic [7:0]      ts_data
);
	timeunit 1ns;
	timeprecision 1ps;
	logic slow = 1'b0;

	initial
	begin
		ts_valid = 1'b0;
		ts_sop = 1'b0;
		ts_data = 8'h00;
	end

	// ----
	// one packet, byte per valid cycle
	// ----
	task automatic send(input logic [7:0] p [188]);
		for (int i = 0; i < 188; i++)
		begin
			// idle gap scrambles data so a stale byte never looks valid
			if (slow && i % 7 == 3)
			begin
				ts_valid <= 1'b0;
				ts_data <= ~ts_data;
				@(posedge aclk);
			end
			ts_valid <= 1'b1;
			ts_sop <= (i == 0);
			ts_data <= p[i];
			@(posedge aclk);
		end
		ts_valid <= 1'b0;
		ts_sop <= 1'b0;
		ts_data <= ~p[187];
		// one idle edge so a following packet never re-drives in this step
		@(posedge aclk);
	endtask
endmodule

/* tb_psi_table_capture.sv */
module tb_psi_table_capture
	import ptc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic              aclk = 1'b0, aresetn = 1'b0;
	logic [AXI_AW-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0]       s_axi_wdata = '0, s_axi_rdata, mem_waddr, ab, mb, pa, pm;
	logic [3:0]        s_axi_wstrb = 4'hf;
	logic [1:0]        s_axi_bresp, s_axi_rresp;
	logic              s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
	logic              s_axi_bready = 1'b1, s_axi_rready = 1'b1;
	logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic              ts_valid, ts_sop, mem_wvalid, irq;
	logic [7:0]        ts_data, mem_wdata;
	logic [12:0]       mp;
	logic [31:0]       seed = 32'h0000_dafe;
	logic [33:0]       rq [$];
	logic [39:0]       mq [$];
	logic [1:0]        bq [$];
	int                fails = 0, tests_run = 0;

	ptc_capture i_ptc_capture (.*);
	ptc_ts_source i_ptc_ts_source (.*);

	always #20 aclk = ~aclk;

	// ----
	// helpers
	// ----
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	task automatic chk(input logic [40:0] s, input logic [40:0] e);
		tests_run++;
		if (s !== e)
		begin
			fails++;
			$display("[FAIL] %0t seen %h expected %h", $time, s, e);
		end
	endtask

	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// handshakes judged at negedge, where ready is settled for the next edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic ta, tw, tb;
		ta = 1'b0;
		tw = 1'b0;
		bq.push_back(a > 8'h23 ? RESP_SLVERR : RESP_OKAY);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		while (!(ta && tw))
		begin
			@(negedge aclk);
			ta = ta || s_axi_awready;
			tw = tw || s_axi_wready;
			@(posedge aclk);
			if (ta)
				s_axi_awvalid <= 1'b0;
			if (tw)
				s_axi_wvalid <= 1'b0;
		end
		do
		begin
			@(negedge aclk);
			tb = s_axi_bvalid;
			@(posedge aclk);
		end
		while (!tb);
	endtask

	task automatic rd(input logic [7:0] a, input logic [33:0] e);
		logic t;
		rq.push_back(e);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do
		begin
			@(negedge aclk);
			t = s_axi_arready;
			@(posedge aclk);
		end
		while (!t);
		s_axi_arvalid <= 1'b0;
		do
		begin
			@(negedge aclk);
			t = s_axi_rvalid;
			@(posedge aclk);
		end
		while (!t);
	endtask

	task automatic irq_is(input logic e);
		@(negedge aclk);
		chk(41'(irq), 41'(e));
		@(posedge aclk);
	endtask

	task automatic pkt(input logic [12:0] id, input logic pu, input logic [4:0] ver,
		input logic st, inout logic [31:0] ptr);
		logic [7:0] p [188];
		for (int i = 0; i < 188; i++)
			p[i] = 8'(xs());
		p[0] = 8'h47;
		p[1] = {1'b0, pu, 1'b0, id[12:8]};
		p[2] = id[7:0];
		p[3] = 8'h10;
		p[4] = 8'h00;
		if (pu)
			p[10] = {2'b11, ver, 1'b1};
		if (st)
			for (int i = pu ? 5 : 4; i < 188; i++)
			begin
				mq.push_back({ptr, p[i]});
				ptr = ptr + 32'h0000_0001;
			end
		i_ptc_ts_source.send(p);
	endtask

	// ----
	// result watchers
	// ----
	always @(negedge aclk)
		if (s_axi_rvalid)
			chk({s_axi_rresp, s_axi_rdata}, rq.pop_front());

	always @(negedge aclk)
		if (mem_wvalid)
			chk({mem_waddr, mem_wdata}, mq.pop_front());

	always @(negedge aclk)
		if (s_axi_bvalid)
			chk(41'(s_axi_bresp), 41'(bq.pop_front()));

	initial
	begin
		repeat (20000) @(posedge aclk);
		fails++;
		end_sim();
	end

	initial
	begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rd(OFS_BND_ID, 34'h0_0000_1fff);
		rd(OFS_MAP_CFG, 34'h0_0000_0000);
		wr(OFS_MAP_CFG, 32'hffff_ffff);
		rd(OFS_MAP_CFG, 34'h0_0001_1fff);
		rd(8'h40, {RESP_SLVERR, 32'h0000_0000});
		wr(8'h40, 32'hffff_ffff);
		ab = xs();
		mb = xs();
		mp = {5'h02, 8'(xs())};
		wr(OFS_ASSOC_BASE, ab);
		wr(OFS_MAP_BASE, mb);
		wr(OFS_ASSOC_CFG, 32'h0001_0000);
		wr(OFS_INT_EN, 32'h0000_000d);
		wr(OFS_MAP_CFG, {19'h0_0008, mp});
		rd(OFS_MAP_BASE, {2'b00, mb});
		pa = ab;
		pkt(13'h0000, 1'b1, 5'h03, 1'b1, pa);
		rd(OFS_INT_STAT, 34'h0_0000_0004);
		irq_is(1'b1);
		pkt(13'h0000, 1'b0, 5'h00, 1'b1, pa);
		wr(OFS_INT_CLR, 32'h0000_0004);
		rd(OFS_INT_STAT, 34'h0_0000_0000);
		irq_is(1'b0);
		// slower source from here: gaps inside packets
		i_ptc_ts_source.slow = 1'b1;
		pkt(13'h0000, 1'b1, 5'h03, 1'b0, pa);
		pkt(13'h0000, 1'b0, 5'h00, 1'b0, pa);
		rd(OFS_INT_STAT, 34'h0_0000_0000);
		pm = mb;
		pkt(mp, 1'b1, 5'h07, 1'b1, pm);
		pkt(mp ^ 13'h0001, 1'b1, 5'h09, 1'b0, pm);
		pkt(mp, 1'b0, 5'h00, 1'b1, pm);
		rd(OFS_INT_STAT, 34'h0_0000_0008);
		wr(OFS_INT_CLR, 32'h0000_0008);
		wr(OFS_MAP_CFG, {19'h0_0000, mp});
		pkt(mp, 1'b1, 5'h0b, 1'b0, pm);
		rd(OFS_INT_STAT, 34'h0_0000_0000);
		ab = xs();
		pa = ab;
		wr(OFS_ASSOC_BASE, ab);
		pkt(13'h0000, 1'b1, 5'h04, 1'b1, pa);
		wr(OFS_INT_EN, 32'h0000_0000);
		irq_is(1'b0);
		wr(OFS_BND_ID, 32'hffff_0155);
		rd(OFS_BND_ID, 34'h0_0000_0155);
		wr(OFS_CONTROL_WORD_ZERO, 32'h0000_0001);
		pkt(13'h0155, 1'b0, 5'h00, 1'b0, pa);
		rd(OFS_CONTROL_WORD_ZERO, 34'h0_0000_0101);
		rd(OFS_INT_STAT, 34'h0_0000_0005);
		wr(OFS_INT_EN, 32'h0000_0001);
		irq_is(1'b1);
		repeat (4) @(posedge aclk);
		chk(41'(mq.size()), 41'h0);
		end_sim();
	end
endmodule

bind ptc_capture ptc_capture_props i_ptc_capture_props (.*);
